// ==== osmc_pkg.sv ====
// Purpose: shared constants and types for the output shutoff and mixer
//          configuration block
// Assumes: 32-bit AXI4-Lite data, 8-bit byte addresses
// Notes: register offsets are word indices; byte address is index * 4
package osmc_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned INDEX_W = 6;

  // register indices
  localparam logic [5:0] CFG_INDEX = 6'h02;
  localparam logic [5:0] STATUS_INDEX = 6'h04;
  localparam logic [5:0] MASK_INDEX = 6'h05;
  localparam logic [5:0] LIVE_INDEX = 6'h06;

  // configuration register layout
  localparam int unsigned CFG_W = 16;
  localparam logic [15:0] CFG_RESET = 16'h7000;
  localparam logic [15:0] CFG_WRITABLE = 16'h70E0;
  localparam int unsigned CFG_DACCLK_BIT = 14;
  localparam int unsigned CFG_DATACLK_BIT = 13;
  localparam int unsigned CFG_COLLISION_BIT = 12;
  localparam int unsigned CFG_FOUR_WIRE_BIT = 7;
  localparam int unsigned CFG_MIXER_BIT = 6;
  localparam int unsigned CFG_GAIN_BIT = 5;

  // alarm mask bits consulted for the shutoff paths
  localparam int unsigned MASK_COLLISION_BIT = 13;
  localparam int unsigned MASK_DACCLK_BIT = 10;
  localparam int unsigned MASK_DATACLK_BIT = 9;
  localparam int unsigned MASK_OUTPUT_BIT = 8;

  // interrupt status and mask layout
  localparam int unsigned EVT_W = 4;
  localparam logic [3:0] EVT_RESET = 4'h0;
  localparam int unsigned EVT_DACCLK_BIT = 0;
  localparam int unsigned EVT_DATACLK_BIT = 1;
  localparam int unsigned EVT_COLLISION_BIT = 2;
  localparam int unsigned EVT_SHUTOFF_BIT = 3;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // monitor indications entering the block
  typedef struct packed {
    logic fifo_collision;
    logic dataclk_lost;
    logic dacclk_lost;
  } osmc_alarm_type;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } osmc_wr_state_type;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } osmc_rd_state_type;

endpackage

// ==== osmc_sync.sv ====
// Purpose: two-stage level synchroniser for monitor indications
// Assumes: inputs are quasi-static levels from another domain
// Notes: only the second stage leaves this module
`timescale 1ns/10ps
`default_nettype none
module osmc_sync #(
  parameter int unsigned WIDTH = 3
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // stage1 feeds stage two and nothing else
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// ==== osmc_top.sv ====
// Purpose: output shutoff and mixer configuration register with AXI4-Lite
//          access, shutoff decision and alarm interrupt
// Assumes: alarm mask comes from logic on aclk; monitor alarms are async
// Notes: reserved and unimplemented bits read as zero
//
// Functional notes
// - conversion clock loss shuts outputs if unmasked
// - data clock loss shuts outputs if unmasked
// - fifo collision shuts outputs if unmasked
// - bit 7 selects four or three wire
// - bit 6 enables mixing stage
// - bit 5 adds fixed 6 dB mixer gain
// - register resets to 0x7000
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module osmc_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi write address
  input wire logic [osmc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi write data
  input wire logic [osmc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi read address
  input wire logic [osmc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi read data
  output logic [osmc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // monitor alarms and mask
  input wire osmc_pkg::osmc_alarm_type alarm_in,
  input wire logic [15:0] alarm_mask_register,
  // control outputs
  output logic analog_output_off,
  output logic four_wire_port_select,
  output logic mixer_enable,
  output logic mixer_gain_boost,
  // interrupt
  output logic irq
);

  // state
  osmc_pkg::osmc_wr_state_type wr_state;
  osmc_pkg::osmc_wr_state_type next_wr_state;
  osmc_pkg::osmc_rd_state_type rd_state;
  osmc_pkg::osmc_rd_state_type next_rd_state;

  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic [osmc_pkg::INDEX_W-1:0] wr_index;
  logic [osmc_pkg::DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;

  logic [osmc_pkg::CFG_W-1:0] cfg;
  logic [osmc_pkg::EVT_W-1:0] status;
  logic [osmc_pkg::EVT_W-1:0] mask;
  logic [osmc_pkg::EVT_W-1:0] next_status;

  osmc_pkg::osmc_alarm_type alarm_sync;
  osmc_pkg::osmc_alarm_type alarm_prev;

  // handshakes
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire b_fire = s_axi_bvalid & s_axi_bready;
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire r_fire = s_axi_rvalid & s_axi_rready;

  // monitor alarms cross in through two flops
  osmc_sync #(
    .WIDTH(3)
  ) alarm_sync_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(alarm_in),
    .sync_out(alarm_sync)
  );

  // write commits once both address and data are held
  wire wr_commit = (wr_state == osmc_pkg::WR_IDLE) & aw_held & w_held;

  wire wr_hit_cfg = wr_index == osmc_pkg::CFG_INDEX;
  wire wr_hit_status = wr_index == osmc_pkg::STATUS_INDEX;
  wire wr_hit_mask = wr_index == osmc_pkg::MASK_INDEX;
  wire wr_hit_live = wr_index == osmc_pkg::LIVE_INDEX;
  wire wr_mapped = wr_hit_cfg | wr_hit_status | wr_hit_mask | wr_hit_live;

  wire cfg_we = wr_commit & wr_hit_cfg;
  wire status_we = wr_commit & wr_hit_status & wr_strb[0];
  wire mask_we = wr_commit & wr_hit_mask & wr_strb[0];

  // byte lanes of the 16-bit register
  wire [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // reserved bits are not stored, so a stray one cannot stick
  wire [15:0] cfg_keep = lane_mask & osmc_pkg::CFG_WRITABLE;
  wire [15:0] next_cfg = (cfg & ~cfg_keep) | (wr_data[15:0] & cfg_keep);

  // shutoff paths, each gated by its own enable and two mask bits
  wire dacclk_path = cfg[osmc_pkg::CFG_DACCLK_BIT]
    & alarm_sync.dacclk_lost
    & ~alarm_mask_register[osmc_pkg::MASK_DACCLK_BIT]
    & ~alarm_mask_register[osmc_pkg::MASK_OUTPUT_BIT];
  wire dataclk_path = cfg[osmc_pkg::CFG_DATACLK_BIT]
    & alarm_sync.dataclk_lost
    & ~alarm_mask_register[osmc_pkg::MASK_DATACLK_BIT]
    & ~alarm_mask_register[osmc_pkg::MASK_OUTPUT_BIT];
  wire collision_path = cfg[osmc_pkg::CFG_COLLISION_BIT]
    & alarm_sync.fifo_collision
    & ~alarm_mask_register[osmc_pkg::MASK_COLLISION_BIT]
    & ~alarm_mask_register[osmc_pkg::MASK_OUTPUT_BIT];
  wire next_output_off = dacclk_path | dataclk_path | collision_path;

  // rising edges of the synchronised alarms and of the shutoff
  wire [osmc_pkg::EVT_W-1:0] evt_set = {
    next_output_off & ~analog_output_off,
    alarm_sync.fifo_collision & ~alarm_prev.fifo_collision,
    alarm_sync.dataclk_lost & ~alarm_prev.dataclk_lost,
    alarm_sync.dacclk_lost & ~alarm_prev.dacclk_lost
  };

  // write one to clear; a set in the same cycle wins
  wire [osmc_pkg::EVT_W-1:0] evt_clr =
    status_we ? wr_data[osmc_pkg::EVT_W-1:0] : '0;

  always_comb begin
    next_status = (status & ~evt_clr) | evt_set;
  end

  wire [osmc_pkg::EVT_W-1:0] next_mask =
    mask_we ? wr_data[osmc_pkg::EVT_W-1:0] : mask;

  // irq follows the mask written this cycle, not the stale one
  wire next_irq = |(next_status & next_mask);

  // read decode
  wire [osmc_pkg::INDEX_W-1:0] rd_index =
    s_axi_araddr[osmc_pkg::ADDR_W-1:2];
  wire rd_hit_cfg = rd_index == osmc_pkg::CFG_INDEX;
  wire rd_hit_status = rd_index == osmc_pkg::STATUS_INDEX;
  wire rd_hit_mask = rd_index == osmc_pkg::MASK_INDEX;
  wire rd_hit_live = rd_index == osmc_pkg::LIVE_INDEX;
  wire rd_mapped = rd_hit_cfg | rd_hit_status | rd_hit_mask | rd_hit_live;

  // live view: synced alarm levels and the shutoff itself
  wire [osmc_pkg::EVT_W-1:0] live_view = {
    analog_output_off,
    alarm_sync.fifo_collision,
    alarm_sync.dataclk_lost,
    alarm_sync.dacclk_lost
  };

  wire [osmc_pkg::DATA_W-1:0] rd_word =
    rd_hit_cfg ? {16'h0000, cfg} :
    rd_hit_status ? {28'h000_0000, status} :
    rd_hit_mask ? {28'h000_0000, mask} :
    rd_hit_live ? {28'h000_0000, live_view} :
    32'h0000_0000;

  wire [1:0] rd_resp = rd_mapped ? osmc_pkg::RESP_OKAY
                                 : osmc_pkg::RESP_SLVERR;

  // write channel sequencing
  always_comb begin
    next_wr_state = wr_state;
    next_aw_held = aw_held | aw_fire;
    next_w_held = w_held | w_fire;
    unique case (wr_state)
      osmc_pkg::WR_IDLE: begin
        if (wr_commit) begin
          next_wr_state = osmc_pkg::WR_RESP;
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
        end
      end
      osmc_pkg::WR_RESP: begin
        if (b_fire) begin
          next_wr_state = osmc_pkg::WR_IDLE;
        end
      end
      default: begin
        next_wr_state = osmc_pkg::WR_IDLE;
      end
    endcase
  end

  // read channel sequencing
  always_comb begin
    next_rd_state = rd_state;
    unique case (rd_state)
      osmc_pkg::RD_IDLE: begin
        if (ar_fire) begin
          next_rd_state = osmc_pkg::RD_DATA;
        end
      end
      osmc_pkg::RD_DATA: begin
        if (r_fire) begin
          next_rd_state = osmc_pkg::RD_IDLE;
        end
      end
      default: begin
        next_rd_state = osmc_pkg::RD_IDLE;
      end
    endcase
  end

  wire next_awready = (next_wr_state == osmc_pkg::WR_IDLE) & ~next_aw_held;
  wire next_wready = (next_wr_state == osmc_pkg::WR_IDLE) & ~next_w_held;
  wire next_arready = next_rd_state == osmc_pkg::RD_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= osmc_pkg::WR_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      wr_state <= next_wr_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
    end
  end

  // payload latches need no reset
  always_ff @(posedge aclk) begin
    if (aw_fire) begin
      wr_index <= s_axi_awaddr[osmc_pkg::ADDR_W-1:2];
    end
    if (w_fire) begin
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= osmc_pkg::RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? osmc_pkg::RESP_OKAY
                               : osmc_pkg::RESP_SLVERR;
    end else if (b_fire) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= osmc_pkg::RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= osmc_pkg::RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rd_state == osmc_pkg::RD_DATA;
      if (ar_fire) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_resp;
      end
    end
  end

  // configuration register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= osmc_pkg::CFG_RESET;
    end else if (cfg_we) begin
      cfg <= next_cfg;
    end
  end

  // mode bits drive the port and mixer straight from the register
  assign four_wire_port_select = cfg[osmc_pkg::CFG_FOUR_WIRE_BIT];
  assign mixer_enable = cfg[osmc_pkg::CFG_MIXER_BIT];
  assign mixer_gain_boost = cfg[osmc_pkg::CFG_GAIN_BIT];

  // shutoff is registered, one cycle after the synced alarm
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_output_off <= 1'b0;
      alarm_prev <= '0;
    end else begin
      analog_output_off <= next_output_off;
      alarm_prev <= alarm_sync;
    end
  end

  // interrupt status, mask and output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= osmc_pkg::EVT_RESET;
      mask <= osmc_pkg::EVT_RESET;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      irq <= next_irq;
    end
  end

  // protection bits carry no meaning here
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_araddr[1:0]};

endmodule
`default_nettype wire

// ==== osmc_top_props.sv ====
// Purpose: port assertions for osmc_top
// Assumes: bus and alarm latencies of osmc_top
// Notes: bound to every osmc_top instance
`timescale 1ns/10ps
`default_nettype none
module osmc_top_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // alarms and controls
  input wire osmc_pkg::osmc_alarm_type alarm_in,
  input wire logic [15:0] alarm_mask_register,
  input wire logic analog_output_off,
  input wire logic four_wire_port_select,
  input wire logic mixer_enable,
  input wire logic mixer_gain_boost,
  input wire logic irq
);
  logic [7:0] wa;
  logic [7:0] ra;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [2:0] a1, a2, a3;
  logic [15:0] m1;
  logic map_ok;
  logic cfg_wr;
  assign map_ok = wa[7:2] inside {6'h02, 6'h04, 6'h05, 6'h06};
  assign cfg_wr = s_axi_bvalid && wa[7:2] == osmc_pkg::CFG_INDEX && ws[0];
  // alarm pipe mirrors the two sync flops plus output flop
  always_ff @(posedge aclk) begin
    a1 <= alarm_in;
    a2 <= a1;
    a3 <= a2;
    m1 <= alarm_mask_register;
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
    if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb;
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_off_quiet: assert property (
    ~|a3 |-> !analog_output_off) else $error("off without alarm");
  chk_off_cause: assert property (
    analog_output_off |-> !m1[8] && (a3[0] && !m1[10] ||
    a3[1] && !m1[9] || a3[2] && !m1[13])) else $error("off while masked");
  chk_four_wire: assert property (
    cfg_wr |-> four_wire_port_select == wd[7]) else $error("port width");
  chk_mixer_on: assert property (
    cfg_wr |-> mixer_enable == wd[6]) else $error("mixer enable");
  chk_mixer_gain: assert property (
    cfg_wr |-> mixer_gain_boost == wd[5]) else $error("mixer gain");
  chk_reset_outs: assert property (
    $rose(aresetn) |-> !analog_output_off && !irq && !mixer_enable &&
    !mixer_gain_boost && !four_wire_port_select) else $error("reset outs");
  chk_cfg_rsvd: assert property (
    s_axi_rvalid && ra[7:2] == osmc_pkg::CFG_INDEX |->
    (s_axi_rdata & ~32'h0000_70E0) == 0) else $error("reserved bits");
  chk_bresp_map: assert property (
    s_axi_bvalid |-> s_axi_bresp == (map_ok ? osmc_pkg::RESP_OKAY :
    osmc_pkg::RESP_SLVERR)) else $error("write response");
  chk_read_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rvalid");
  cov_cfg: cover property (cfg_wr);
  cov_off: cover property ($rose(analog_output_off));
  cov_irq: cover property ($rose(irq));
endmodule
bind osmc_top osmc_top_props i_osmc_top_props (.*);
`default_nettype wire

// ==== osmc_top_tb.sv ====
// Purpose: self-checking bench for osmc_top
// Assumes: 125 MHz aclk, synchronous active-low reset
// Notes: bus results queued by the driver, checked by a monitor
`timescale 1ns/10ps
`default_nettype none
module osmc_top_tb;
  logic aclk, aresetn, awv, awr, wv, wr_rdy, bv, bry, arv, arr, rv, rry;
  logic off, fw, mx, gb, irq;
  logic [7:0] aw, ar;
  logic [31:0] wd, rd, d;
  logic [3:0] ws, s;
  logic [1:0] br, rr;
  logic [15:0] mk, m, cfg;
  osmc_pkg::osmc_alarm_type al;
  logic [33:0] qb[$];
  logic [33:0] qr[$];
  logic [33:0] qp[$];
  int fails, total_checks, cyc, i, j;
  int seed = 56;
  osmc_top i_osmc_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .alarm_in(al), .alarm_mask_register(mk),
    .analog_output_off(off), .four_wire_port_select(fw),
    .mixer_enable(mx), .mixer_gain_boost(gb), .irq(irq));
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  task automatic check(input string n, input logic [33:0] e,
                       input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (bv && bry) check("bresp", qb.pop_front(), {32'h0, br});
    if (rv && rry) check("rdata", qr.pop_front(), {rr, rd});
    if (cyc == 20000) begin
      fails++;
      print_verdict;
    end
  end
  // settled outputs are looked at on the falling edge
  always @(negedge aclk) begin
    if (qp.size() > 0) begin
      check("pins", qp.pop_front(), {29'h0, irq, off, fw, mx, gb});
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] st, input logic [1:0] e);
    logic ta;
    logic tw;
    ta = 0;
    tw = 0;
    qb.push_back({32'h0, e});
    aw <= a;
    wd <= v;
    ws <= st;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awr && awv) begin
        ta = 1;
        awv <= 0;
      end
      if (wr_rdy && wv) begin
        tw = 1;
        wv <= 0;
      end
    end
    do @(posedge aclk); while (!bv);
    bry <= 0;
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [33:0] e);
    qr.push_back(e);
    ar <= a;
    arv <= 1;
    rry <= 1;
    do @(posedge aclk); while (!arr);
    arv <= 0;
    do @(posedge aclk); while (!rv);
    rry <= 0;
    @(posedge aclk);
  endtask
  task automatic pins(input logic [4:0] e);
    qp.push_back({29'h0, e});
    @(negedge aclk);
    @(posedge aclk);
  endtask
  initial begin
    {aresetn, awv, wv, bry, arv, rry, aw, ar, wd, ws, mk} = 0;
    al = 3'b000;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    pins(5'h00);
    rdc(8'h08, {2'h0, 32'h0000_7000});
    cfg = 16'h7000;
    for (i = 0; i < 6; i++) begin
      d = $random(seed);
      d[15:0] = d[15:0] & osmc_pkg::CFG_WRITABLE;
      s = $random(seed);
      m = {{8{s[1]}}, {8{s[0]}}};
      cfg = (cfg & ~m | d[15:0] & m) & osmc_pkg::CFG_WRITABLE;
      wr(8'h08, d, s, osmc_pkg::RESP_OKAY);
      pins({2'b00, cfg[7:5]});
      rdc(8'h08, {18'h0, cfg});
    end
    wr(8'h0C, 32'hFFFF_FFFF, 4'hF, osmc_pkg::RESP_SLVERR);
    rdc(8'h0C, {osmc_pkg::RESP_SLVERR, 32'h0});
    for (i = 0; i < 3; i++) begin
      for (j = 0; j < 4; j++) begin
        wr(8'h08, (j == 1) ? 32'h0 : 32'h1 << (14 - i), 4'hF, 2'h0);
        mk <= (j == 3) ? 16'h0100 : (j == 2) ? 16'h1 << (i == 2 ? 13 :
              10 - i) : 16'h0;
        al <= 3'b001 << i;
        repeat (3) @(posedge aclk);
        pins({1'b0, j == 0, 3'b000});
        al <= 3'b000;
        repeat (3) @(posedge aclk);
        pins(5'h00);
      end
    end
    rdc(8'h10, 34'hF);
    wr(8'h10, 32'hF, 4'hF, osmc_pkg::RESP_OKAY);
    rdc(8'h10, 34'h0);
    wr(8'h08, 32'h0000_4000, 4'hF, osmc_pkg::RESP_OKAY);
    wr(8'h14, 32'h1, 4'hF, osmc_pkg::RESP_OKAY);
    mk <= 16'h0;
    al <= 3'b001;
    repeat (3) @(posedge aclk);
    pins(5'h18);
    wr(8'h18, 32'h0, 4'hF, osmc_pkg::RESP_OKAY);
    rdc(8'h18, 34'h9);
    al <= 3'b000;
    wr(8'h14, 32'h0, 4'hF, osmc_pkg::RESP_OKAY);
    pins(5'h00);
    wr(8'h14, 32'h1, 4'hF, osmc_pkg::RESP_OKAY);
    pins(5'h10);
    rdc(8'h10, 34'h9);
    wr(8'h10, 32'h1, 4'hF, osmc_pkg::RESP_OKAY);
    pins(5'h00);
    rdc(8'h10, 34'h8);
    print_verdict;
  end
endmodule
`default_nettype wire
